// ### logic/isb_pkg.sv
`default_nettype none
package isb_pkg;

  // avalon side
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 32;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_IRQ_EN    = 8'ha9;
  localparam logic [7:0] IDX_ADDR_EN   = 8'he9;
  localparam logic [7:0] IDX_CTL       = 8'hea;
  localparam logic [7:0] IDX_RX1       = 8'heb;
  localparam logic [7:0] IDX_RX2_TX    = 8'hec;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'hf0;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'hf1;

  // reset values
  localparam logic [7:0] RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] RST_ADDR_EN   = 8'h64;
  localparam logic [7:0] RST_CTL       = 8'h04;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [2:0] RST_IRQ       = 3'h0;

  // field positions
  localparam int unsigned IRQ_EN_BIT   = 6;
  localparam int unsigned PORT_EN_BIT  = 0;
  localparam int unsigned EV_RX1       = 0;
  localparam int unsigned EV_RX2       = 1;
  localparam int unsigned EV_TXD       = 2;

  // serial framing
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_TX_BIT   = 4'h7;
  localparam logic [1:0] MAX_RX_BYTES  = 2'h2;

  typedef struct packed {
    logic master_irq_en;
    logic transmit_done_irq_en;
    logic second_byte_irq_en;
    logic first_byte_irq_en;
    logic rsvd;
    logic transmit_done_flag;
    logic second_byte_done_flag;
    logic first_byte_done_flag;
  } isb_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h2,
    ST_RX   = 3'h3,
    ST_RACK = 3'h4,
    ST_TX   = 3'h5,
    ST_TACK = 3'h6
  } isb_state_e;

endpackage : isb_pkg
`default_nettype wire

// ### logic/isb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module isb_sync #(
  parameter int unsigned WIDTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;

  // idle bus lines are high, so reset to ones
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_reg <= '1;
      q_o      <= '1;
    end else if (ce_i) begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end

endmodule : isb_sync
`default_nettype wire

// ### logic/isb_slave_port.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - accept at most two received bytes after each start
// - first byte done sets its flag and interrupt if enabled
// - writing zero clears the first byte flag
// - second byte has own flag, interrupt and write-zero clear
// - after a read start, send exactly one byte
// - byte sent sets transmit flag and interrupt if enabled
// - writing zero clears the transmit flag
// - own bus address comes from address register bits 7 to 1
// - control bits 6, 5, 4 enable transmit, second, first irq
// - first byte register returns last first byte, read-only
// - shared register reads second byte, write loads send byte
module isb_slave_port
  import isb_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  output logic                   irq_o
);

  logic       [7:0] peripheral_irq_enable_reg;
  logic       [7:0] slave_address_enable_reg;
  isb_ctl_s         ctl_reg;
  logic       [7:0] first_rx_byte_reg;
  logic       [7:0] second_rx_byte_reg;
  logic       [7:0] tx_byte_reg;
  logic       [2:0] irq_stat_reg;
  logic       [2:0] irq_mask_reg;
  logic       [7:0] rd_byte;

  wire logic        req      = avs_read_i | avs_write_i;
  wire logic        acc      = req & ~avs_waitrequest_o;
  wire logic        wr_acc   = acc & avs_write_i & avs_byteenable_i[0];
  wire logic        rd_acc   = acc & avs_read_i;
  wire logic        aligned  = (avs_address_i[1:0] == 2'h0);
  wire logic [7:0]  idx      = avs_address_i[9:2];
  wire logic        sel_ien  = aligned & (idx == IDX_IRQ_EN);
  wire logic        sel_adr  = aligned & (idx == IDX_ADDR_EN);
  wire logic        sel_ctl  = aligned & (idx == IDX_CTL);
  wire logic        sel_rx1  = aligned & (idx == IDX_RX1);
  wire logic        sel_dat  = aligned & (idx == IDX_RX2_TX);
  wire logic        sel_ist  = aligned & (idx == IDX_IRQ_STAT);
  wire logic        sel_imk  = aligned & (idx == IDX_IRQ_MASK);
  wire logic [7:0]  wbyte    = avs_writedata_i[7:0];
  wire logic        wr_ctl   = wr_acc & sel_ctl;

  // reserved control bit reads as zero; unmapped reads zero
  assign rd_byte = sel_ien ? peripheral_irq_enable_reg :
                   sel_adr ? slave_address_enable_reg :
                   sel_ctl ? (ctl_reg & 8'hf7) :
                   sel_rx1 ? first_rx_byte_reg :
                   sel_dat ? second_rx_byte_reg :
                   sel_ist ? {5'h00, irq_stat_reg} :
                   sel_imk ? {5'h00, irq_mask_reg} :
                   8'h00;

  // one wait state: request seen, then completed on the next edge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= '0;
    end else if (ce_i) begin
      avs_waitrequest_o <= ~(req & avs_waitrequest_o);
      if (req & avs_waitrequest_o) begin
        avs_readdata_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  logic [1:0] pin_q;
  logic       scl_prev_reg;
  logic       sda_prev_reg;

  isb_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .ce_i     (ce_i),
    .d_i      ({scl_i, sda_i}),
    .q_o      (pin_q)
  );

  wire logic scl_q     = pin_q[1];
  wire logic sda_q     = pin_q[0];
  wire logic scl_rise  = scl_q & ~scl_prev_reg;
  wire logic scl_fall  = ~scl_q & scl_prev_reg;
  wire logic scl_hold  = scl_q & scl_prev_reg;
  wire logic start_det = scl_hold & sda_prev_reg & ~sda_q;
  wire logic stop_det  = scl_hold & ~sda_prev_reg & sda_q;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce_i) begin
      scl_prev_reg <= scl_q;
      sda_prev_reg <= sda_q;
    end
  end

  isb_state_e st_reg;
  isb_state_e st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [1:0] rxc_reg;
  logic [1:0] rxc_next;
  logic       rw_reg;
  logic       rw_next;
  logic       oe_reg;
  logic       oe_next;

  wire logic port_en  = slave_address_enable_reg[PORT_EN_BIT];
  wire logic [6:0] own_bus_address = slave_address_enable_reg[7:1];
  wire logic addr_hit = port_en & (shift_reg[7:1] == own_bus_address);
  wire logic byte_end = scl_fall & (cnt_reg == BYTE_BITS);
  wire logic ev_rx1   = (st_reg == ST_RX) & byte_end & (rxc_reg == 2'h0);
  wire logic ev_rx2   = (st_reg == ST_RX) & byte_end & (rxc_reg == 2'h1);
  wire logic ev_txd   = (st_reg == ST_TACK) & scl_rise & port_en
                        & ~start_det & ~stop_det;

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    rxc_next   = rxc_reg;
    rw_next    = rw_reg;
    oe_next    = oe_reg;
    if (!port_en) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start_det) begin
      st_next  = ST_ADDR;
      cnt_next = 4'h0;
      rxc_next = 2'h0;
      oe_next  = 1'b0;
    end else if (stop_det) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else begin
      case (st_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_q};
            cnt_next   = cnt_reg + 4'h1;
          end else if (byte_end) begin
            st_next = addr_hit ? ST_AACK : ST_IDLE;
            oe_next = addr_hit;
            rw_next = shift_reg[0];
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              st_next    = ST_TX;
              shift_next = tx_byte_reg;
              oe_next    = ~tx_byte_reg[7];
            end else begin
              st_next = ST_RX;
              oe_next = 1'b0;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_q};
            cnt_next   = cnt_reg + 4'h1;
          end else if (byte_end) begin
            // a third byte is not acknowledged
            cnt_next = 4'h0;
            rxc_next = (rxc_reg < MAX_RX_BYTES) ? rxc_reg + 2'h1 : rxc_reg;
            st_next  = (rxc_reg < MAX_RX_BYTES) ? ST_RACK : ST_IDLE;
            oe_next  = (rxc_reg < MAX_RX_BYTES);
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            st_next = ST_RX;
            oe_next = 1'b0;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (cnt_reg == LAST_TX_BIT) begin
              st_next = ST_TACK;
              oe_next = 1'b0;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              cnt_next   = cnt_reg + 4'h1;
              oe_next    = ~shift_reg[6];
            end
          end
        end
        ST_TACK: begin
          // back to idle after one byte
          if (scl_rise) begin
            st_next = ST_IDLE;
          end
        end
        default: begin
          st_next = ST_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      rxc_reg   <= 2'h0;
      rw_reg    <= 1'b0;
      oe_reg    <= 1'b0;
    end else if (ce_i) begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      rxc_reg   <= rxc_next;
      rw_reg    <= rw_next;
      oe_reg    <= oe_next;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      sda_o    <= 1'b0;
      sda_oe_o <= oe_next;
    end
  end

  // write zero clears a flag, write one keeps it; an event wins
  wire logic clr_rx1 = wr_ctl & ~wbyte[0];
  wire logic clr_rx2 = wr_ctl & ~wbyte[1];
  wire logic clr_txd = wr_ctl & ~wbyte[2];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      peripheral_irq_enable_reg <= RST_IRQ_EN;
      slave_address_enable_reg  <= RST_ADDR_EN;
      ctl_reg                   <= RST_CTL;
      tx_byte_reg               <= RST_BYTE;
      irq_mask_reg              <= RST_IRQ;
    end else if (ce_i) begin
      if (wr_acc & sel_ien) begin
        peripheral_irq_enable_reg <= wbyte;
      end
      if (wr_acc & sel_adr) begin
        slave_address_enable_reg <= wbyte;
      end
      if (wr_ctl) begin
        ctl_reg.master_irq_en        <= wbyte[7];
        ctl_reg.transmit_done_irq_en <= wbyte[6];
        ctl_reg.second_byte_irq_en   <= wbyte[5];
        ctl_reg.first_byte_irq_en    <= wbyte[4];
      end
      ctl_reg.first_byte_done_flag  <= ev_rx1 |
        (ctl_reg.first_byte_done_flag & ~clr_rx1);
      ctl_reg.second_byte_done_flag <= ev_rx2 |
        (ctl_reg.second_byte_done_flag & ~clr_rx2);
      ctl_reg.transmit_done_flag    <= ev_txd |
        (ctl_reg.transmit_done_flag & ~clr_txd);
      ctl_reg.rsvd <= 1'b0;
      if (wr_acc & sel_dat) begin
        tx_byte_reg <= wbyte;
      end
      if (wr_acc & sel_imk) begin
        irq_mask_reg <= wbyte[2:0];
      end
    end
  end

  // received data have no reset value
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (ev_rx1) begin
        first_rx_byte_reg <= shift_reg;
      end
      if (ev_rx2) begin
        second_rx_byte_reg <= shift_reg;
      end
    end
  end

  logic [2:0] irq_ev;
  // clear only bits that were returned, so a late event survives
  wire logic [2:0] irq_clr = (rd_acc & sel_ist) ? avs_readdata_o[2:0]
                                                : 3'h0;

  assign irq_ev[EV_RX1] = ev_rx1 & ctl_reg.first_byte_irq_en;
  assign irq_ev[EV_RX2] = ev_rx2 & ctl_reg.second_byte_irq_en;
  assign irq_ev[EV_TXD] = ev_txd & ctl_reg.transmit_done_irq_en;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_stat_reg <= RST_IRQ;
      irq_o        <= 1'b0;
    end else if (ce_i) begin
      irq_stat_reg <= irq_ev | (irq_stat_reg & ~irq_clr);
      irq_o        <= |(irq_stat_reg & irq_mask_reg)
                      & peripheral_irq_enable_reg[IRQ_EN_BIT];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  AST_RX1_FLAG_SET: assert property (
    (ce_i && ev_rx1) |=> ctl_reg.first_byte_done_flag
      && first_rx_byte_reg == $past(shift_reg))
    else $error("first byte flag or data not captured");

  AST_RX1_FLAG_CLR: assert property (
    (ce_i && clr_rx1 && !ev_rx1) |=> !ctl_reg.first_byte_done_flag)
    else $error("first byte flag not cleared by zero write");

  AST_RX2_FLAG_SET: assert property (
    (ce_i && ev_rx2) |=> ctl_reg.second_byte_done_flag
      && second_rx_byte_reg == $past(shift_reg))
    else $error("second byte flag or data not captured");

  AST_RX2_FLAG_CLR: assert property (
    (ce_i && clr_rx2 && !ev_rx2) |=> !ctl_reg.second_byte_done_flag)
    else $error("second byte flag not cleared by zero write");

  AST_RX_LIMIT: assert property (
    (st_reg == ST_RX && byte_end && rxc_reg == MAX_RX_BYTES && ce_i
      && port_en && !start_det && !stop_det)
      |=> st_reg == ST_IDLE && !sda_oe_o)
    else $error("third byte was acknowledged");

  AST_TXD_SET: assert property (
    (ce_i && ev_txd) |=> ctl_reg.transmit_done_flag
      && st_reg == ST_IDLE)
    else $error("transmit flag not set at end of byte");

  AST_TXD_CLR: assert property (
    (ce_i && clr_txd && !ev_txd) |=> !ctl_reg.transmit_done_flag)
    else $error("transmit flag not cleared by zero write");

  AST_ADDR_MATCH: assert property (
    (st_reg == ST_AACK) |-> port_en
      && shift_reg[7:1] == slave_address_enable_reg[7:1])
    else $error("address acknowledged without match");

  AST_IRQ_LEVEL: assert property (
    ce_i |=> irq_o == ($past(|(irq_stat_reg & irq_mask_reg))
      && $past(peripheral_irq_enable_reg[IRQ_EN_BIT])))
    else $error("interrupt output does not follow status");

  AST_WAIT_ONE: assert property (
    (ce_i && req && avs_waitrequest_o) ##1 ce_i
      |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

endmodule : isb_slave_port
`default_nettype wire

// ### verif/isb_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
module isb_i2c_master #(
  parameter realtime Q = 31.25
) (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_pull_o
);
  // bus idles with both lines released, clock still between frames
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  task automatic start;
    #Q sda_pull_o = 1'b1;
    #Q scl_o = 1'b0;
  endtask : start

  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    #Q sda_pull_o = ~b;
    #Q scl_o = 1'b1;
    #Q s = sda_i;
    #Q scl_o = 1'b0;
  endtask : bit_io

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack);
  endtask : put_byte

  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nack, s);
  endtask : get_byte

  task automatic stop;
    #Q sda_pull_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_pull_o = 1'b0;
    #Q;
  endtask : stop
endmodule : isb_i2c_master
`default_nettype wire

// ### verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import isb_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              resetn_i;
  logic              ce_i;
  logic [ADDR_W-1:0] a_addr;
  logic              a_rd;
  logic              a_wr;
  logic [DATA_W-1:0] a_wdata;
  logic [3:0]        a_be;
  logic [DATA_W-1:0] a_rdata;
  logic              a_wait;
  logic              sda_o;
  logic              sda_oe;
  logic              irq_o;
  logic              scl;
  logic              m_pull;
  wire               sda_line = ~(m_pull | sda_oe);
  logic [7:0]        expq[$];
  string             nmq[$];
  int                miscompares = 0;
  int                n_compared = 0;
  logic [6:0]        sa;
  logic [7:0]        d1;
  logic [7:0]        d2;
  logic [7:0]        d3;
  logic [7:0]        b;

  always #5 clk_i = ~clk_i;

  isb_slave_port isb_slave_port_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
    .avs_address_i(a_addr), .avs_read_i(a_rd), .avs_write_i(a_wr),
    .avs_writedata_i(a_wdata), .avs_byteenable_i(a_be),
    .avs_readdata_o(a_rdata), .avs_waitrequest_o(a_wait),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .irq_o(irq_o)
  );

  isb_i2c_master isb_i2c_master_inst (
    .sda_i(sda_line), .scl_o(scl), .sda_pull_o(m_pull)
  );

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // read data is taken only at the edge that sees waitrequest low
  always @(posedge clk_i) begin
    if (a_rd && a_wait === 1'b0 && expq.size() > 0) begin
      chk(nmq.pop_front(), {24'h00_0000, expq.pop_front()}, a_rdata);
    end
  end

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    a_addr  <= {idx, 2'b00};
    a_wr    <= w;
    a_rd    <= ~w;
    a_wdata <= ($urandom & 32'hffff_ff00) | {24'h00_0000, d};
    a_be    <= be;
    do begin
      @(posedge clk_i);
      n++;
    end while (a_wait !== 1'b0 && n < 20);
    if (n >= 20) begin
      miscompares++;
      $display("ERROR waitrequest expected 0 seen 1");
    end
    a_rd <= 1'b0;
    a_wr <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [7:0] e,
                    input string nm);
    expq.push_back(e);
    nmq.push_back(nm);
    bus(1'b0, idx, 8'h00, 4'hf);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask : wr

  task automatic send(input logic [7:0] v, input logic e_ack);
    logic a;
    isb_i2c_master_inst.put_byte(v, a);
    chk("ack", {31'h0, e_ack}, {31'h0, a});
  endtask : send

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq_o});
  endtask : irq_is

  initial begin
    #300us;
    miscompares++;
    $display("ERROR watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    resetn_i = 1'b0;
    ce_i     = 1'b1;
    a_addr   = '0;
    a_rd     = 1'b0;
    a_wr     = 1'b0;
    a_wdata  = '0;
    a_be     = 4'h0;
    b        = 8'($urandom(32'hff7ca8d6));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(IDX_IRQ_EN, RST_IRQ_EN, "irq_en");
    rd(IDX_ADDR_EN, RST_ADDR_EN, "addr_en");
    rd(IDX_CTL, RST_CTL, "ctl");
    rd(IDX_IRQ_STAT, 8'h00, "status");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00, "unmapped");
    // port still disabled, so even its own address goes unanswered
    isb_i2c_master_inst.start();
    send({RST_ADDR_EN[7:1], 1'b0}, 1'b1);
    isb_i2c_master_inst.stop();
    sa = 7'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    d3 = 8'($urandom);
    wr(IDX_ADDR_EN, {sa, 1'b1});
    rd(IDX_ADDR_EN, {sa, 1'b1}, "addr_en");
    isb_i2c_master_inst.start();
    send({sa ^ 7'h01, 1'b0}, 1'b1);
    isb_i2c_master_inst.stop();
    wr(IDX_CTL, 8'hf8);
    rd(IDX_CTL, 8'hf0, "ctl");
    wr(IDX_IRQ_EN, 8'h40);
    wr(IDX_IRQ_MASK, 8'h07);
    rd(IDX_IRQ_MASK, 8'h07, "mask");
    irq_is(1'b0);
    isb_i2c_master_inst.start();
    send({sa, 1'b0}, 1'b0);
    send(d1, 1'b0);
    send(d2, 1'b0);
    send(d3, 1'b1);
    isb_i2c_master_inst.stop();
    irq_is(1'b1);
    rd(IDX_RX1, d1, "first_rx_byte");
    rd(IDX_RX2_TX, d2, "second_rx_byte");
    rd(IDX_CTL, 8'hf3, "ctl");
    rd(IDX_IRQ_STAT, 8'h03, "status");
    irq_is(1'b0);
    wr(IDX_RX1, ~d1);
    rd(IDX_RX1, d1, "first_rx_byte");
    wr(IDX_CTL, 8'hf2);
    rd(IDX_CTL, 8'hf2, "ctl");
    wr(IDX_CTL, 8'hf0);
    rd(IDX_CTL, 8'hf0, "ctl");
    bus(1'b1, IDX_CTL, 8'h00, 4'h0);
    rd(IDX_CTL, 8'hf0, "ctl");
    // the shared register write is the byte sent on the next read
    wr(IDX_RX2_TX, d3);
    isb_i2c_master_inst.start();
    send({sa, 1'b1}, 1'b0);
    isb_i2c_master_inst.get_byte(1'b0, b);
    chk("tx_byte", {24'h00_0000, d3}, {24'h00_0000, b});
    isb_i2c_master_inst.get_byte(1'b1, b);
    chk("extra_byte", 32'h0000_00ff, {24'h00_0000, b});
    isb_i2c_master_inst.stop();
    irq_is(1'b1);
    rd(IDX_CTL, 8'hf4, "ctl");
    rd(IDX_IRQ_STAT, 8'h04, "status");
    wr(IDX_CTL, 8'hf0);
    rd(IDX_CTL, 8'hf0, "ctl");
    // masked event still leaves its sticky status bit
    wr(IDX_IRQ_MASK, 8'h00);
    isb_i2c_master_inst.start();
    send({sa, 1'b0}, 1'b0);
    send(d2, 1'b0);
    isb_i2c_master_inst.stop();
    irq_is(1'b0);
    rd(IDX_IRQ_STAT, 8'h01, "status");
    rd(IDX_RX1, d2, "first_rx_byte");
    // a frozen block holds a pending request unanswered
    ce_i <= 1'b0;
    fork
      rd(IDX_IRQ_MASK, 8'h00, "mask");
      begin
        repeat (6) @(posedge clk_i);
        chk("frozen_wait", 32'h0000_0001, {31'h0, a_wait});
        ce_i <= 1'b1;
      end
    join
    chk("sda_o", 32'h0, {31'h0, sda_o});
    repeat (4) @(posedge clk_i);
    close_out();
  end
endmodule : tb
`default_nettype wire
